// File: core/swm_pkg.sv
package swm_pkg;
    // warning indices; output selection code is index + 1
    typedef enum logic [3:0] {
        SWM_W_OVERLOAD, SWM_W_REGEN, SWM_W_BATTERY, SWM_W_FAN, SWM_W_ENC_COMM,
        SWM_W_ENC_HOT, SWM_W_VIBRATION, SWM_W_LIFE, SWM_W_XENC_WARN,
        SWM_W_XENC_COMM, SWM_W_DATA, SWM_W_CMD, SWM_W_NET
    } swm_warn_idx_t;
    localparam int SWM_NWARN = 13;
    typedef struct packed {
        logic        overload;
        logic        regen;
        logic        battery;
        logic        fan_stopped;
        logic        enc_comm_err;
        logic        enc_hot;
        logic        vibration;
        logic        life_low;
        logic        xenc_warn;
        logic        xenc_comm_err;
        logic        data_setting;
        logic        command;
        logic        net_comm_err;
    } swm_cond_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } swm_bus_req_t;
    typedef enum logic [1:0] {SWM_HOLD_NONE, SWM_HOLD_SEL_GEN, SWM_HOLD_SEL_COMM,
                              SWM_HOLD_LATCH} swm_hold_kind_t;
endpackage

// File: core/swm_regs.svh
`ifndef SWM_REGS_SVH
`define SWM_REGS_SVH
// register offsets, as printed
`define SWM_OFS_OUT1_SEL   16'h3440
`define SWM_OFS_OUT2_SEL   16'h3441
`define SWM_OFS_GEN_MASK   16'h3638
`define SWM_OFS_HOLD_SEL   16'h3759
`define SWM_OFS_COMM_CTRL  16'h3800
`define SWM_OFS_CTRL       16'h3900
`define SWM_OFS_STATUS     16'h3901
`define SWM_OFS_ENC_LIMIT  16'h3902
`define SWM_OFS_XENC_LIMIT 16'h3903
// hold selection fields
`define SWM_HOLD_COMM_BIT  0
`define SWM_HOLD_GEN_BIT   1
// control register fields
`define SWM_CTRL_RESET_BIT 0
`define SWM_CTRL_INC20_BIT 1
// general mask bit of each warning
`define SWM_MBIT_OVERLOAD  7
`define SWM_MBIT_REGEN     5
`define SWM_MBIT_BATTERY   0
`define SWM_MBIT_FAN       6
`define SWM_MBIT_ENC_COMM  4
`define SWM_MBIT_ENC_HOT   3
`define SWM_MBIT_VIBRATION 9
`define SWM_MBIT_LIFE      2
`define SWM_MBIT_XENC_WARN 8
`define SWM_MBIT_XENC_COMM 10
// communications warnings: mask bits in the communications control
`define SWM_CBIT_DATA      4
`define SWM_CBIT_CMD       5
`define SWM_CBIT_NET       6
// reset values
`define SWM_RST_SEL        16'h0000
`define SWM_RST_MASK       16'h0000
`define SWM_RST_HOLD       16'h0000
`define SWM_RST_COMM       16'h0000
`define SWM_RST_LIMIT      8'h03
// fan stop time
`define SWM_FAN_STOP_MS    1000
`define SWM_CLK_HZ         20000000
`define SWM_FAN_CYCLES     ((`SWM_CLK_HZ / 1000) * `SWM_FAN_STOP_MS)
`endif

// File: core/swm_warning_manager.sv
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`include "swm_regs.svh"
module swm_warning_manager
    import swm_pkg::*;
(
    input  wire logic         ref_clk_i,
    input  wire logic         sys_rst_i,
    input  wire swm_bus_req_t bus_i,
    output logic [15:0]       rdata_o,
    input  wire swm_cond_t    cond_i,
    input  wire logic         enc_err_strobe_i,
    input  wire logic         enc_ok_strobe_i,
    input  wire logic         xenc_err_strobe_i,
    input  wire logic         xenc_ok_strobe_i,
    input  wire logic         enc_batt_hold_i,
    output logic              warning_out_first_o,
    output logic              warning_out_second_o
);
    localparam int FAN_CYC = `SWM_FAN_CYCLES;

    // conditions come from pins: two flops before use
    swm_cond_t   cond_s1;
    swm_cond_t   cond_s2;
    logic [3:0]  strb_s1;
    logic [3:0]  strb_s2;
    logic [3:0]  strb_s3;
    logic        batt_s1;
    logic        batt_s2;

    logic [15:0] out1_sel;
    logic [15:0] out2_sel;
    logic [15:0] gen_mask;
    logic [15:0] hold_sel;
    logic [15:0] comm_ctrl;
    logic        inc20_enc;
    logic [7:0]  enc_limit;
    logic [7:0]  xenc_limit;
    logic [7:0]  enc_run;
    logic [7:0]  xenc_run;
    logic [24:0] fan_cnt;
    logic [SWM_NWARN-1:0] active;
    logic        err_reset;

    always_ff @(posedge ref_clk_i) begin
        cond_s1 <= cond_i;
        cond_s2 <= cond_s1;
        strb_s1 <= {xenc_ok_strobe_i, xenc_err_strobe_i, enc_ok_strobe_i, enc_err_strobe_i};
        strb_s2 <= strb_s1;
        strb_s3 <= strb_s2;
        batt_s1 <= enc_batt_hold_i;
        batt_s2 <= batt_s1;
    end

    // pulse strobes become one-cycle events on rising edge
    wire [3:0] strb_rise = strb_s2 & ~strb_s3;

    function automatic logic [7:0] run_next(input logic [7:0] cur, input logic err,
                                            input logic ok);
        if (ok)
            return 8'h00;
        else if (err && cur != 8'hff)
            return cur + 8'h01;
        else
            return cur;
    endfunction

    // register bus
    wire wr_out1  = bus_i.wr && bus_i.addr == `SWM_OFS_OUT1_SEL;
    wire wr_out2  = bus_i.wr && bus_i.addr == `SWM_OFS_OUT2_SEL;
    wire wr_mask  = bus_i.wr && bus_i.addr == `SWM_OFS_GEN_MASK;
    wire wr_hold  = bus_i.wr && bus_i.addr == `SWM_OFS_HOLD_SEL;
    wire wr_comm  = bus_i.wr && bus_i.addr == `SWM_OFS_COMM_CTRL;
    wire wr_ctrl  = bus_i.wr && bus_i.addr == `SWM_OFS_CTRL;
    wire wr_elim  = bus_i.wr && bus_i.addr == `SWM_OFS_ENC_LIMIT;
    wire wr_xlim  = bus_i.wr && bus_i.addr == `SWM_OFS_XENC_LIMIT;

    // self-clearing reset command bit
    wire next_err_reset = wr_ctrl && bus_i.wdata[`SWM_CTRL_RESET_BIT];

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            out1_sel   <= `SWM_RST_SEL;
            out2_sel   <= `SWM_RST_SEL;
            gen_mask   <= `SWM_RST_MASK;
            hold_sel   <= `SWM_RST_HOLD;
            comm_ctrl  <= `SWM_RST_COMM;
            inc20_enc  <= 1'b0;
            enc_limit  <= `SWM_RST_LIMIT;
            xenc_limit <= `SWM_RST_LIMIT;
            err_reset  <= 1'b0;
        end else begin
            if (wr_out1) out1_sel <= bus_i.wdata;
            if (wr_out2) out2_sel <= bus_i.wdata;
            if (wr_mask) gen_mask <= bus_i.wdata;
            if (wr_hold) hold_sel <= bus_i.wdata;
            if (wr_comm) comm_ctrl <= bus_i.wdata;
            if (wr_ctrl) inc20_enc <= bus_i.wdata[`SWM_CTRL_INC20_BIT];
            if (wr_elim) enc_limit <= bus_i.wdata[7:0];
            if (wr_xlim) xenc_limit <= bus_i.wdata[7:0];
            err_reset <= next_err_reset;
        end
    end

    // read data one cycle later; unmapped reads zero
    wire [15:0] next_rdata =
        !bus_i.rd                           ? 16'h0000 :
        bus_i.addr == `SWM_OFS_OUT1_SEL     ? out1_sel :
        bus_i.addr == `SWM_OFS_OUT2_SEL     ? out2_sel :
        bus_i.addr == `SWM_OFS_GEN_MASK     ? gen_mask :
        bus_i.addr == `SWM_OFS_HOLD_SEL     ? hold_sel :
        bus_i.addr == `SWM_OFS_COMM_CTRL    ? comm_ctrl :
        bus_i.addr == `SWM_OFS_CTRL         ? {14'h0000, inc20_enc, 1'b0} :
        bus_i.addr == `SWM_OFS_STATUS       ? {3'h0, active} :
        bus_i.addr == `SWM_OFS_ENC_LIMIT    ? {8'h00, enc_limit} :
        bus_i.addr == `SWM_OFS_XENC_LIMIT   ? {8'h00, xenc_limit} :
        16'h0000;

    // consecutive error counters and fan timer
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            enc_run  <= 8'h00;
            xenc_run <= 8'h00;
            fan_cnt  <= 25'h0000000;
        end else begin
            enc_run  <= run_next(enc_run, strb_rise[0], strb_rise[1]);
            xenc_run <= run_next(xenc_run, strb_rise[2], strb_rise[3]);
            if (!cond_s2.fan_stopped)
                fan_cnt <= 25'h0000000;
            else if (fan_cnt != 25'(FAN_CYC))
                fan_cnt <= fan_cnt + 25'h0000001;
        end
    end

    // raw detection per warning, index order as swm_warn_idx_t
    wire [SWM_NWARN-1:0] raw;
    assign raw[SWM_W_OVERLOAD]  = cond_s2.overload;
    assign raw[SWM_W_REGEN]     = cond_s2.regen;
    assign raw[SWM_W_BATTERY]   = cond_s2.battery;
    assign raw[SWM_W_FAN]       = fan_cnt == 25'(FAN_CYC);
    assign raw[SWM_W_ENC_COMM]  = enc_run > enc_limit;
    assign raw[SWM_W_ENC_HOT]   = cond_s2.enc_hot && inc20_enc;
    assign raw[SWM_W_VIBRATION] = cond_s2.vibration;
    assign raw[SWM_W_LIFE]      = cond_s2.life_low;
    assign raw[SWM_W_XENC_WARN] = cond_s2.xenc_warn;
    assign raw[SWM_W_XENC_COMM] = xenc_run > xenc_limit;
    assign raw[SWM_W_DATA]      = cond_s2.data_setting;
    assign raw[SWM_W_CMD]       = cond_s2.command;
    assign raw[SWM_W_NET]       = cond_s2.net_comm_err;

    // detection masks
    logic [SWM_NWARN-1:0] masked;
    assign masked = {comm_ctrl[`SWM_CBIT_NET], comm_ctrl[`SWM_CBIT_CMD],
                     comm_ctrl[`SWM_CBIT_DATA],
                     gen_mask[`SWM_MBIT_XENC_COMM], gen_mask[`SWM_MBIT_XENC_WARN],
                     gen_mask[`SWM_MBIT_LIFE], gen_mask[`SWM_MBIT_VIBRATION],
                     gen_mask[`SWM_MBIT_ENC_HOT], gen_mask[`SWM_MBIT_ENC_COMM],
                     gen_mask[`SWM_MBIT_FAN], gen_mask[`SWM_MBIT_BATTERY],
                     gen_mask[`SWM_MBIT_REGEN], gen_mask[`SWM_MBIT_OVERLOAD]};
    wire [SWM_NWARN-1:0] detect = raw & ~masked;

    // hold kind per warning; non-switchable non-latch ones auto clear
    wire hold_gen  = hold_sel[`SWM_HOLD_GEN_BIT];
    wire hold_comm = hold_sel[`SWM_HOLD_COMM_BIT];
    logic [SWM_NWARN-1:0] held;
    assign held = {hold_comm, 1'b0, hold_comm,      // cmd warning not switchable
                   hold_gen, 1'b0, 1'b1, 1'b0,
                   hold_gen, hold_gen, hold_gen, 1'b1, hold_gen, hold_gen};

    // battery latch waits for encoder hold release
    wire [SWM_NWARN-1:0] batt_keep = batt_s2 ? (13'h0001 << SWM_W_BATTERY) : 13'h0000;
    wire [SWM_NWARN-1:0] clr_reset = err_reset ? ~batt_keep : 13'h0000;

    // detection wins over clear, so a persistent cause reasserts at once
    wire [SWM_NWARN-1:0] next_active =
        detect | (active & held & ~clr_reset);

    // outputs follow a selection written in the same cycle
    wire [15:0] next_out1_sel = wr_out1 ? bus_i.wdata : out1_sel;
    wire [15:0] next_out2_sel = wr_out2 ? bus_i.wdata : out2_sel;

    function automatic logic sel_hit(input logic [15:0] sel,
                                     input logic [SWM_NWARN-1:0] act);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < SWM_NWARN; i++)
            if (act[i] && (sel == 16'h0000 || sel == 16'(i + 1)))
                hit = 1'b1;
        return hit;
    endfunction

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            active               <= '0;
            rdata_o              <= 16'h0000;
            warning_out_first_o  <= 1'b0;
            warning_out_second_o <= 1'b0;
        end else begin
            active               <= next_active;
            rdata_o              <= next_rdata;
            warning_out_first_o  <= sel_hit(next_out1_sel, next_active);
            warning_out_second_o <= sel_hit(next_out2_sel, next_active);
        end
    end

    AST_OUT_MATCH: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        warning_out_first_o == sel_hit(out1_sel, active))
        else $error("first output disagrees with active set");
    AST_ANY_SEL: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (out2_sel == 16'h0000 && active != '0) |-> warning_out_second_o)
        else $error("zero selection missed a warning");
    AST_AUTO_CLR: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (!hold_gen && !detect[SWM_W_OVERLOAD]) |=> !active[SWM_W_OVERLOAD])
        else $error("non-held overload stayed");
    AST_HOLD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (hold_gen && active[SWM_W_REGEN] && !err_reset) |=> active[SWM_W_REGEN])
        else $error("held warning dropped");
    AST_LATCH_LIFE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (active[SWM_W_LIFE] && !err_reset) |=> active[SWM_W_LIFE])
        else $error("life warning not latched");
    AST_MASK: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (gen_mask[`SWM_MBIT_FAN] && !active[SWM_W_FAN]) |=> !active[SWM_W_FAN])
        else $error("masked fan warning raised");
    AST_COMM_MASK: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (comm_ctrl[`SWM_CBIT_NET] && !active[SWM_W_NET]) |=> !active[SWM_W_NET])
        else $error("masked comm warning raised");
    AST_RESET_CLR: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (err_reset && !detect[SWM_W_OVERLOAD]) |=> !active[SWM_W_OVERLOAD])
        else $error("reset did not clear warning");
    AST_BATT_KEEP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (active[SWM_W_BATTERY] && batt_s2) |=> active[SWM_W_BATTERY])
        else $error("battery cleared under encoder hold");
    AST_ENC_HOT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (!inc20_enc && !active[SWM_W_ENC_HOT]) |=> !active[SWM_W_ENC_HOT])
        else $error("overheat raised on wrong encoder");
    // per-warning set and clear paths; fan timer too long for the bench to reach

    AST_OUT2_MATCH: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        warning_out_second_o == sel_hit(out2_sel, active))
        else $error("second output disagrees with active set");

    AST_ANY_SEL_FIRST: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (out1_sel == 16'h0000 && active != '0) |-> warning_out_first_o)
        else $error("zero selection missed a warning on first output");

    AST_OUT_IDLE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (active == '0) |-> (!warning_out_first_o && !warning_out_second_o))
        else $error("output high with no active warning");

    AST_SEL_MISS: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (out1_sel == 16'h0001 && !active[SWM_W_OVERLOAD]) |-> !warning_out_first_o)
        else $error("first output high for an unselected warning");

    AST_AUTO_CLR_REGEN: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (!hold_gen && !detect[SWM_W_REGEN]) |=> !active[SWM_W_REGEN])
        else $error("non-held regeneration warning stayed");

    AST_AUTO_CLR_VIB: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !detect[SWM_W_VIBRATION] |=> !active[SWM_W_VIBRATION])
        else $error("vibration warning held");

    AST_AUTO_CLR_XENC: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !detect[SWM_W_XENC_WARN] |=> !active[SWM_W_XENC_WARN])
        else $error("external encoder warning held");

    AST_COMM_HOLD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (hold_comm && active[SWM_W_DATA] && !err_reset) |=> active[SWM_W_DATA])
        else $error("held comm warning dropped");

    AST_COMM_AUTO: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (!hold_comm && !detect[SWM_W_DATA]) |=> !active[SWM_W_DATA])
        else $error("non-held comm warning stayed");

    AST_LATCH_BATT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (active[SWM_W_BATTERY] && !err_reset) |=> active[SWM_W_BATTERY])
        else $error("battery warning not latched");

    AST_OVERLOAD_SET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (cond_s2.overload && !gen_mask[`SWM_MBIT_OVERLOAD]) |=> active[SWM_W_OVERLOAD])
        else $error("overload warning not raised");

    AST_REGEN_SET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (cond_s2.regen && !gen_mask[`SWM_MBIT_REGEN]) |=> active[SWM_W_REGEN])
        else $error("regeneration warning not raised");

    AST_BATT_SET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (cond_s2.battery && !gen_mask[`SWM_MBIT_BATTERY]) |=> active[SWM_W_BATTERY])
        else $error("battery warning not raised");

    AST_FAN_SET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (fan_cnt == 25'(FAN_CYC) && !gen_mask[`SWM_MBIT_FAN]) |=> active[SWM_W_FAN])
        else $error("fan warning not raised");

    AST_FAN_EARLY: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (fan_cnt != 25'(FAN_CYC) && !active[SWM_W_FAN]) |=> !active[SWM_W_FAN])
        else $error("fan warning raised early");

    AST_ENC_COMM_SET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (enc_run > enc_limit && !gen_mask[`SWM_MBIT_ENC_COMM]) |=> active[SWM_W_ENC_COMM])
        else $error("encoder comm warning not raised");

    AST_XENC_COMM_SET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (xenc_run > xenc_limit && !gen_mask[`SWM_MBIT_XENC_COMM]) |=> active[SWM_W_XENC_COMM])
        else $error("external comm warning not raised");

    AST_ENC_RUN_CLR: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        strb_rise[1] |=> (enc_run == 8'h00))
        else $error("good frame did not restart error count");

    AST_ENC_HOT_SET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (cond_s2.enc_hot && inc20_enc && !gen_mask[`SWM_MBIT_ENC_HOT]) |=> active[SWM_W_ENC_HOT])
        else $error("overheat warning not raised");

    AST_LIFE_SET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (cond_s2.life_low && !gen_mask[`SWM_MBIT_LIFE]) |=> active[SWM_W_LIFE])
        else $error("life warning not raised");

    AST_BATT_RELEASE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (err_reset && !batt_s2 && !detect[SWM_W_BATTERY]) |=> !active[SWM_W_BATTERY])
        else $error("battery kept after encoder release");

    AST_XENC_SET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (cond_s2.xenc_warn && !gen_mask[`SWM_MBIT_XENC_WARN]) |=> active[SWM_W_XENC_WARN])
        else $error("external encoder warning not raised");
endmodule

// File: sim/swm_host_model.sv
`timescale 1ns/100ps
`include "swm_regs.svh"
module swm_host_model
    import swm_pkg::*;
(
    input  wire logic         ref_clk_i,
    input  wire logic [15:0]  rdata_i,
    output swm_bus_req_t      bus_o
);
    initial bus_o = '0;

    // released address and data show the inverse, never the last value
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        // selections only ever carry zero or a listed code
        if ((a == `SWM_OFS_OUT1_SEL || a == `SWM_OFS_OUT2_SEL) && d > 16'h000d) v = '0;
        @(posedge ref_clk_i);
        bus_o <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_i);
        bus_o <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        bus_o <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_i);
        bus_o <= '{addr: ~a, wdata: 16'hffff, wr: 1'b0, rd: 1'b0};
        #1 d = rdata_i;
    endtask

    // error reset also writes the encoder type bit from inc
    task automatic clear(input logic inc);
        wr(`SWM_OFS_CTRL, {14'h0000, inc, 1'b1});
    endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/100ps
`include "swm_regs.svh"
module tb;
    logic                  ref_clk_i = 1'b0;
    logic                  sys_rst_i = 1'b1;
    swm_pkg::swm_bus_req_t bus;
    logic [15:0]           rdata;
    logic [12:0]           cond = '0;
    logic [3:0]            stb = '0;
    logic                  batt_hold = 1'b0;
    logic                  out1;
    logic                  out2;
    int                    fails = 0;
    int                    total_checks = 0;
    int                    seed = 54203;
    logic [15:0]           r, sel1, sel2, hold, gmask, cmask;

    always #25 ref_clk_i = ~ref_clk_i;

    swm_host_model host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .bus_o(bus));
    swm_warning_manager dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
        .rdata_o(rdata), .cond_i(cond), .enc_err_strobe_i(stb[0]), .enc_ok_strobe_i(stb[1]),
        .xenc_err_strobe_i(stb[2]), .xenc_ok_strobe_i(stb[3]), .enc_batt_hold_i(batt_hold),
        .warning_out_first_o(out1), .warning_out_second_o(out2));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    function automatic logic latched(input int i, input logic [15:0] h);
        case (i)
            2, 7: return 1'b1;
            6, 8, 11: return 1'b0;
            10, 12: return h[0];
            default: return h[1];
        endcase
    endfunction

    function automatic logic masked(input int i);
        int mb[13] = '{7, 5, 0, 6, 4, 3, 9, 2, 8, 10, 4, 5, 6};
        return (i >= 10) ? cmask[mb[i]] : gmask[mb[i]];
    endfunction

    // monitors need three edges to show through the synchronisers
    task automatic strobe(input int b, input int n);
        repeat (n) begin
            @(posedge ref_clk_i) stb[b] <= 1'b1;
            repeat (3) @(posedge ref_clk_i);
            stb[b] <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
        end
    endtask

    task automatic one_warn(input int i);
        logic on;
        sel1 = 16'($unsigned($random(seed)) % 14);
        sel2 = ($random(seed) & 1) ? 16'h0000 : 16'(i + 1);
        hold = 16'($random(seed)) & 16'h0003;
        gmask = 16'($random(seed)) & 16'h07ff;
        cmask = 16'($random(seed)) & 16'h0070;
        host.wr(`SWM_OFS_OUT1_SEL, sel1);
        host.wr(`SWM_OFS_OUT2_SEL, sel2);
        host.wr(`SWM_OFS_HOLD_SEL, hold);
        host.wr(`SWM_OFS_GEN_MASK, gmask);
        host.wr(`SWM_OFS_COMM_CTRL, cmask);
        host.rd(`SWM_OFS_OUT1_SEL, r);
        check(r, sel1);
        on = !masked(i);
        @(posedge ref_clk_i) cond[12-i] <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        host.rd(`SWM_OFS_STATUS, r);
        check(r, 16'(on) << i);
        check(out1, on && (sel1 == 16'h0000 || sel1 == 16'(i + 1)));
        check(out2, on);
        @(posedge ref_clk_i) cond[12-i] <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        on = on && latched(i, hold);
        host.rd(`SWM_OFS_STATUS, r);
        check(r, 16'(on) << i);
        check(out2, on);
        if (i == 2) begin
            batt_hold <= 1'b1;
            host.clear(1'b1);
            repeat (4) @(posedge ref_clk_i);
            host.rd(`SWM_OFS_STATUS, r);
            check(r, 16'(on) << i);
            batt_hold <= 1'b0;
        end
        host.clear(1'b1);
        repeat (4) @(posedge ref_clk_i);
        host.rd(`SWM_OFS_STATUS, r);
        check(r, 16'h0000);
    endtask

    task automatic comm_errs(input int x, input int lim);
        logic [15:0] a;
        a = x ? `SWM_OFS_XENC_LIMIT : `SWM_OFS_ENC_LIMIT;
        host.wr(a, 16'(lim));
        host.wr(`SWM_OFS_HOLD_SEL, 16'h0000);
        host.wr(`SWM_OFS_GEN_MASK, 16'h0000);
        host.rd(a, r);
        check(r, 16'(lim));
        // a good frame in between restarts the consecutive count
        strobe(2 * x, lim);
        strobe(2 * x + 1, 1);
        strobe(2 * x, lim);
        host.rd(`SWM_OFS_STATUS, r);
        check(r, 16'h0000);
        strobe(2 * x, 1);
        host.rd(`SWM_OFS_STATUS, r);
        check(r, 16'h0001 << (x ? 9 : 4));
        strobe(2 * x + 1, 1);
        host.rd(`SWM_OFS_STATUS, r);
        check(r, 16'h0000);
    endtask

    logic [15:0] regs[8] = '{16'h3440, 16'h3441, 16'h3638, 16'h3759, 16'h3800,
                             16'h3902, 16'h3903, 16'h3a00};
    logic [15:0] rstv[8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                             16'h0003, 16'h0003, 16'h0000};
    int          list[10] = '{0, 1, 2, 5, 6, 7, 8, 10, 11, 12};

    initial begin
        repeat (10) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        foreach (regs[k]) begin
            host.rd(regs[k], r);
            check(r, rstv[k]);
        end
        // overheat ignored until the 20-bit incremental encoder is selected
        @(posedge ref_clk_i) cond[7] <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        host.rd(`SWM_OFS_STATUS, r);
        check(r, 16'h0000);
        @(posedge ref_clk_i) cond[7] <= 1'b0;
        host.wr(`SWM_OFS_CTRL, 16'h0002);
        repeat (3) begin
            foreach (list[k]) one_warn(list[k]);
        end
        // reset with the cause still present: the warning comes straight back
        host.wr(`SWM_OFS_HOLD_SEL, 16'h0002);
        host.wr(`SWM_OFS_GEN_MASK, 16'h0000);
        @(posedge ref_clk_i) cond[12] <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        host.clear(1'b1);
        repeat (6) @(posedge ref_clk_i);
        host.rd(`SWM_OFS_STATUS, r);
        check(r, 16'h0001);
        @(posedge ref_clk_i) cond[12] <= 1'b0;
        host.clear(1'b1);
        comm_errs(0, 3);
        comm_errs(1, 1 + ($unsigned($random(seed)) % 4));
        conclude();
    end
endmodule
